//--- rtl/chan_diag_regs.vh
// Register map, field positions and timing counts for the channel diagnostic block
`ifndef CHAN_DIAG_REGS_VH
`define CHAN_DIAG_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_PATH 0
`define CTRL_CFG0 1
`define CTRL_CFG1 2
`define CTRL_PEN 3
`define CTRL_INS 4
`define CTRL_RLB 5
`define CTRL_LLB 6
`define CTRL_E3 7

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_LIMIT 0
`define ST_LOSS 1
`define ST_FILL_LSB 8

// ----------------------------------------------------------------
// Dejitter buffer settings
// ----------------------------------------------------------------
`define DJ_OFF 2'b00
`define DJ_SHORT 2'b01
`define DJ_LONG 2'b10
`define DJ_LIMIT_MARGIN 6'h02
`define DJ_AVG_SEED 12'h0c8
`define DJ_AVG_SHIFT 4
`define DJ_IV_MAX 8'hff

// ----------------------------------------------------------------
// Pattern generator and checker
// ----------------------------------------------------------------
`define PAT_SEED 23'h000001
`define PAT_SYNC_GOOD 6'h20
`define PAT_ERR_FORGIVE 6'h10
`define PAT_ERR_LOSS 3'h4
`define E3_TAP_A 22
`define E3_TAP_B 17
`define DS3_TAP_A 14
`define DS3_TAP_B 13

// ----------------------------------------------------------------
// Positions of the pins in the input synchroniser
// ----------------------------------------------------------------
`define PIN_TXC 0
`define PIN_TXP 1
`define PIN_TXN 2
`define PIN_RXC 3
`define PIN_RXP 4
`define PIN_RXN 5
`define PIN_COUNT 6

`endif

//--- rtl/dejitter_buffer.v
// Elastic buffer of the jitter attenuator with selectable depth and limit detect
`include "chan_diag_regs.vh"
`default_nettype none

module dejitter_buffer #(
  parameter WIDTH = 2,
  parameter AW = 5,
  parameter [AW:0] MARGIN = `DJ_LIMIT_MARGIN
) (
  input wire clk_sys,
  input wire resetn,
  input wire flush,
  input wire deep,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  output reg [WIDTH-1:0] rd_data,
  output reg [AW:0] fill,
  output wire near_limit
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  integer i;

  // Capacity follows the depth select; short depth uses half the array
  wire [AW:0] cap = deep ? {1'b1, {AW{1'b0}}} : {2'b01, {(AW-1){1'b0}}};
  wire [AW-1:0] last = cap[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
  wire do_wr = wr_en && (fill != cap);
  wire do_rd = rd_en && (fill != {(AW+1){1'b0}});

  // Within two entries of empty or of full
  assign near_limit = (fill <= MARGIN) || (fill >= cap - MARGIN);

  // Pointers wrap at the chosen capacity; a flush recentres the buffer
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
      rd_data <= {WIDTH{1'b0}};
    end else if (flush) begin
      wp_r <= cap[AW:1];
      rp_r <= {AW{1'b0}};
      fill <= {1'b0, cap[AW:1]};
    end else begin
      if (do_wr)
        wp_r <= (wp_r == last) ? {AW{1'b0}} : wp_r + 1'b1;
      if (do_rd) begin
        rp_r <= (rp_r == last) ? {AW{1'b0}} : rp_r + 1'b1;
        rd_data <= mem[rp_r];
      end
      fill <= fill + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end

  // Storage; a flush also clears stale contents
  always @(posedge clk_sys) begin
    if (flush) begin
      for (i = 0; i < (1 << AW); i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end else if (do_wr) begin
      mem[wp_r] <= wr_data;
    end
  end

endmodule

`default_nettype wire

//--- rtl/channel_prbs_and_jitter_fifo.v
// Channel diagnostics: jitter attenuator buffer, pattern generator/checker, loopbacks
//
// Our own choices: the register addresses and register access over Avalon-MM.
`include "chan_diag_regs.vh"
`default_nettype none

module channel_prbs_and_jitter_fifo #(
  parameter AW = 5
) (
  input wire clk_sys,
  input wire resetn,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire tx_line_clock,
  input wire tx_pos_rail,
  input wire tx_neg_rail,
  input wire rx_recovered_clock,
  input wire rx_line_plus,
  input wire rx_line_minus,
  output reg tx_clock_out,
  output reg tx_line_pos_out,
  output reg tx_line_neg_out,
  output reg rx_clock_out,
  output reg rx_pos_rail,
  output reg rx_neg_violation_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [`PIN_COUNT-1:0] s1_r;
  reg [`PIN_COUNT-1:0] s2_r;
  reg [`PIN_COUNT-1:0] s3_r;
  reg [`PIN_COUNT-1:0] pin_r;
  wire [`PIN_COUNT-1:0] pin_in;
  wire [`PIN_COUNT-1:0] agree = ~(s2_r ^ s3_r);
  wire [`PIN_COUNT-1:0] pin_nxt = (agree & s3_r) | (~agree & pin_r);
  wire [`PIN_COUNT-1:0] pin_rise = pin_nxt & ~pin_r;

  assign pin_in = {rx_line_minus, rx_line_plus, rx_recovered_clock, tx_neg_rail, tx_pos_rail, tx_line_clock};

  // Three stages; a level counts once stages two and three agree
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_r <= {`PIN_COUNT{1'b0}};
      s2_r <= {`PIN_COUNT{1'b0}};
      s3_r <= {`PIN_COUNT{1'b0}};
      pin_r <= {`PIN_COUNT{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg limit_r;
  reg sync_r;
  reg flush_r;
  reg ins_pend_r;
  wire [AW:0] fill;
  wire near_limit;
  wire acc = (read || write) && !waitrequest;
  wire wr_ctrl = acc && write && (address == `OFF_CTRL);
  wire rd_status = acc && read && (address == `OFF_STATUS);
  wire pen = ctrl_r[`CTRL_PEN];
  wire e3 = ctrl_r[`CTRL_E3];
  wire [1:0] dj_cfg = {ctrl_r[`CTRL_CFG1], ctrl_r[`CTRL_CFG0]};
  wire ja_on = (dj_cfg == `DJ_SHORT) || (dj_cfg == `DJ_LONG);
  wire deep = (dj_cfg == `DJ_LONG);
  wire ja_tx = ja_on && ctrl_r[`CTRL_PATH];
  wire ja_rx = ja_on && !ctrl_r[`CTRL_PATH];
  wire rlb = ctrl_r[`CTRL_RLB];
  wire llb = ctrl_r[`CTRL_LLB];
  wire remote = rlb && !llb;
  wire digital = !rlb && llb;
  wire analog = rlb && llb;
  reg [31:0] rd_mux;

  // Read data for the addressed register; unmapped reads return zero
  always @* begin
    rd_mux = 32'h00000000;
    if (address == `OFF_CTRL) begin
      rd_mux[7:0] = ctrl_r;
    end else if (address == `OFF_STATUS) begin
      rd_mux[`ST_LIMIT] = limit_r;
      rd_mux[`ST_LOSS] = pen && !sync_r;
      rd_mux[`ST_FILL_LSB+AW:`ST_FILL_LSB] = fill;
    end
  end

  // One wait state: request seen, then answered with waitrequest low
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      ctrl_r <= `CTRL_RESET;
    end else begin
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
        if (read)
          readdata <= rd_mux;
      end else begin
        waitrequest <= 1'b1;
      end
      if (wr_ctrl)
        ctrl_r <= writedata[7:0];
    end
  end

  // Arrival at the limit is the event; a fill that stays there cannot block the clearing read
  reg near_q_r;
  wire lim_cond = ja_on && near_limit && !flush_r;

  // Limit flag: hardware set wins over the clearing read
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      limit_r <= 1'b0;
      flush_r <= 1'b1;
      near_q_r <= 1'b0;
    end else begin
      limit_r <= (lim_cond && !near_q_r) || (limit_r && !rd_status);
      flush_r <= rd_status || wr_ctrl;
      near_q_r <= lim_cond;
    end
  end

  // ----------------------------------------------------------------
  // Stream selection
  // ----------------------------------------------------------------
  wire txc_rise = pin_rise[`PIN_TXC];
  wire [1:0] tx_in = {pin_nxt[`PIN_TXN], pin_nxt[`PIN_TXP]};
  reg pace_r;
  reg gen_bit;
  wire [1:0] buf_out;
  wire line_ev = analog ? txc_rise : pin_rise[`PIN_RXC];
  wire [1:0] line_dat = analog ? {tx_line_neg_out, tx_line_pos_out} : {pin_nxt[`PIN_RXN], pin_nxt[`PIN_RXP]};
  wire rxa_ev = ja_rx ? pace_r : line_ev;
  wire [1:0] rxa_dat = ja_rx ? buf_out : line_dat;
  wire gen_ev = txc_rise && !remote;
  wire [1:0] gen_dat = pen ? {1'b0, gen_bit} : tx_in;
  wire src_ev = remote ? rxa_ev : gen_ev;
  wire [1:0] src_dat = remote ? rxa_dat : gen_dat;
  wire txo_ev = ja_tx ? pace_r : src_ev;
  wire [1:0] txo_dat = ja_tx ? buf_out : src_dat;
  wire buf_wr = ja_rx ? line_ev : src_ev;
  wire [1:0] buf_wdat = ja_rx ? line_dat : src_dat;

  dejitter_buffer #(
    .WIDTH(2),
    .AW(AW)
  ) u_buf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .flush(flush_r),
    .deep(deep),
    .wr_en(buf_wr && ja_on),
    .wr_data(buf_wdat),
    .rd_en(pace_r && ja_on),
    .rd_data(buf_out),
    .fill(fill),
    .near_limit(near_limit)
  );

  // ----------------------------------------------------------------
  // Smoothed read clock
  // ----------------------------------------------------------------
  reg [7:0] iv_r;
  reg [11:0] avg_r;
  reg [7:0] pc_r;
  reg dj_clk_r;
  wire [7:0] base = avg_r[11:`DJ_AVG_SHIFT];
  wire [AW:0] half = {1'b0, (deep ? {1'b1, {(AW-1){1'b0}}} : {2'b01, {(AW-2){1'b0}}})};
  reg [7:0] tgt;

  // Period follows buffer fill: drain faster above half, slower below
  always @* begin
    tgt = base;
    if (fill > half && base > 8'h02)
      tgt = base - 8'h01;
    else if (fill < half && base != `DJ_IV_MAX)
      tgt = base + 8'h01;
  end

  // Average write interval drives an evenly spaced read strobe
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      iv_r <= 8'h01;
      avg_r <= `DJ_AVG_SEED;
      pc_r <= 8'h00;
      pace_r <= 1'b0;
      dj_clk_r <= 1'b0;
    end else begin
      if (buf_wr && ja_on) begin
        iv_r <= 8'h01;
        avg_r <= avg_r - (avg_r >> `DJ_AVG_SHIFT) + {4'h0, iv_r};
      end else if (iv_r != `DJ_IV_MAX) begin
        iv_r <= iv_r + 8'h01;
      end
      pace_r <= ja_on && (pc_r >= tgt);
      pc_r <= (pc_r >= tgt) ? 8'h00 : pc_r + 8'h01;
      dj_clk_r <= (pc_r < {1'b0, tgt[7:1]});
    end
  end

  // ----------------------------------------------------------------
  // Pattern generator
  // ----------------------------------------------------------------
  reg [22:0] gen_r;
  wire gen_fb = e3 ? (gen_r[`E3_TAP_A] ^ gen_r[`E3_TAP_B]) : (gen_r[`DS3_TAP_A] ^ gen_r[`DS3_TAP_B]);
  wire ins_rise = wr_ctrl && writedata[`CTRL_INS] && !ctrl_r[`CTRL_INS] && writedata[`CTRL_PEN];

  always @* begin
    gen_bit = gen_fb ^ ins_pend_r;
  end

  // Shift once per transmit clock; a pending insertion flips one bit
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gen_r <= `PAT_SEED;
      ins_pend_r <= 1'b0;
    end else begin
      if (pen && gen_ev)
        gen_r <= {gen_r[21:0], gen_fb};
      ins_pend_r <= ins_rise || (ins_pend_r && !(pen && gen_ev));
    end
  end

  // ----------------------------------------------------------------
  // Pattern checker
  // ----------------------------------------------------------------
  reg [22:0] chk_r;
  reg [5:0] good_r;
  reg [2:0] bad_r;
  reg err_pulse_r;
  wire chk_exp = e3 ? (chk_r[`E3_TAP_A] ^ chk_r[`E3_TAP_B]) : (chk_r[`DS3_TAP_A] ^ chk_r[`DS3_TAP_B]);
  wire chk_err = rxa_dat[0] != chk_exp;

  // Self-synchronising compare; sync after a clean run, lost after errors
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chk_r <= 23'h000000;
      good_r <= 6'h00;
      bad_r <= 3'h0;
      sync_r <= 1'b0;
      err_pulse_r <= 1'b0;
    end else if (!pen) begin
      good_r <= 6'h00;
      bad_r <= 3'h0;
      sync_r <= 1'b0;
      err_pulse_r <= 1'b0;
    end else if (rxa_ev) begin
      // In sync the reference runs on itself, so one line error counts once
      chk_r <= {chk_r[21:0], sync_r ? chk_exp : rxa_dat[0]};
      err_pulse_r <= chk_err && sync_r;
      if (chk_err) begin
        good_r <= 6'h00;
        if (sync_r) begin
          bad_r <= bad_r + 3'h1;
          if (bad_r + 3'h1 == `PAT_ERR_LOSS)
            sync_r <= 1'b0;
        end
      end else begin
        if (good_r != `PAT_SYNC_GOOD)
          good_r <= good_r + 6'h01;
        if (good_r + 6'h01 == `PAT_SYNC_GOOD)
          sync_r <= 1'b1;
        if (good_r + 6'h01 == `PAT_ERR_FORGIVE)
          bad_r <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // Transmit pins update on their own event; single rail in pattern mode
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_line_pos_out <= 1'b0;
      tx_line_neg_out <= 1'b0;
      tx_clock_out <= 1'b0;
    end else begin
      if (txo_ev)
        tx_line_pos_out <= txo_dat[0];
      if (pen)
        tx_line_neg_out <= 1'b0;
      else if (txo_ev)
        tx_line_neg_out <= txo_dat[1];
      if (ja_tx)
        tx_clock_out <= dj_clk_r;
      else if (remote)
        tx_clock_out <= analog ? pin_r[`PIN_TXC] : pin_r[`PIN_RXC];
      else
        tx_clock_out <= pin_r[`PIN_TXC];
    end
  end

  // Receive pins: digital loop, pattern indication or received stream
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_clock_out <= 1'b0;
      rx_pos_rail <= 1'b0;
      rx_neg_violation_out <= 1'b0;
    end else if (digital) begin
      rx_clock_out <= pin_r[`PIN_TXC];
      rx_pos_rail <= pin_r[`PIN_TXP];
      rx_neg_violation_out <= pin_r[`PIN_TXN];
    end else begin
      rx_clock_out <= ja_rx ? dj_clk_r : (analog ? pin_r[`PIN_TXC] : pin_r[`PIN_RXC]);
      if (rxa_ev)
        rx_pos_rail <= rxa_dat[0];
      if (pen)
        rx_neg_violation_out <= !sync_r || err_pulse_r;
      else if (rxa_ev)
        rx_neg_violation_out <= rxa_dat[1];
    end
  end

endmodule

`default_nettype wire

//--- tb/channel_prbs_and_jitter_fifo_monitor.sv
// Port checker for the channel diagnostic block
`include "chan_diag_regs.vh"
`default_nettype none
module chan_diag_monitor (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic tx_line_neg_out,
  input wire logic rx_neg_violation_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ctrl_r;
  logic in_rst_r = 1'b0;
  wire rd_ok = read && !waitrequest;
  // Marks edges that lie inside a reset already held for one edge
  always @(posedge clk_sys) in_rst_r <= !resetn;
  // ----------------------------------------------------------------
  // Shadow of the control register
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (write && !waitrequest && address == `OFF_CTRL) begin
      ctrl_r <= writedata[7:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_wait_answer: assert property ($rose(read || write) |=> !waitrequest)
    else $error("request not answered after one wait state");
  chk_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_read_stable: assert property (!$stable(readdata) |-> rd_ok)
    else $error("read data changed outside an accepted read");
  chk_unmapped_zero: assert property (rd_ok && address != `OFF_CTRL && address != `OFF_STATUS |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (rd_ok && address == `OFF_CTRL |-> readdata[7:0] == ctrl_r)
    else $error("control readback differs from last write");
  chk_loss_pen: assert property (
    rd_ok && address == `OFF_STATUS && readdata[`ST_LOSS] |-> ctrl_r[`CTRL_PEN] || $past(ctrl_r[`CTRL_PEN]))
    else $error("sync loss reported with pattern off");
  chk_single_rail: assert property (ctrl_r[`CTRL_PEN] && $past(ctrl_r[`CTRL_PEN], 3) |-> !tx_line_neg_out)
    else $error("negative rail active in pattern mode");
  chk_reset_idle: assert property (disable iff (1'b0)
    in_rst_r && !resetn |-> waitrequest && readdata == 32'h0 && !rx_neg_violation_out)
    else $error("outputs not idle in reset");
  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------
  cov_limit: cover property (rd_ok && address == `OFF_STATUS && readdata[`ST_LIMIT]);
  cov_lock: cover property ($fell(rx_neg_violation_out) && ctrl_r[`CTRL_PEN]);
  cov_unmapped: cover property (rd_ok && address == 4'h8);
endmodule

bind channel_prbs_and_jitter_fifo chan_diag_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .tx_line_neg_out(tx_line_neg_out), .rx_neg_violation_out(rx_neg_violation_out));
`default_nettype wire

//--- tb/framer_model.sv
// Framer-side model: link clock, transmit rails and receive rails
`default_nettype none
module framer_model (
  input wire logic run,
  input wire logic loop_en,
  input wire logic tp,
  input wire logic tn,
  input wire logic rp,
  input wire logic rn,
  input wire logic tx_line_pos_out,
  input wire logic tx_line_neg_out,
  output logic tx_line_clock,
  output logic tx_pos_rail,
  output logic tx_neg_rail,
  output logic rx_recovered_clock,
  output logic rx_line_plus,
  output logic rx_line_minus
);
  timeunit 1ns;
  timeprecision 100ps;
  assign rx_recovered_clock = tx_line_clock;
  // Link clock, standing still low while the link is stopped
  initial begin
    tx_line_clock = 1'b0;
    #3;
    forever begin
      #62.5;
      tx_line_clock = run ? ~tx_line_clock : 1'b0;
    end
  end
  // Rails change mid-bit, away from the sampling edge
  initial {tx_pos_rail, tx_neg_rail, rx_line_plus, rx_line_minus} = 4'h0;
  always @(negedge tx_line_clock) begin
    tx_pos_rail <= tp;
    tx_neg_rail <= tn;
    rx_line_plus <= loop_en ? tx_line_pos_out : rp;
    rx_line_minus <= loop_en ? tx_line_neg_out : rn;
  end
endmodule
`default_nettype wire

//--- tb/channel_prbs_and_jitter_fifo_tb.sv
// Self-checking bench for the channel diagnostic block
`include "chan_diag_regs.vh"
`default_nettype none
module channel_prbs_and_jitter_fifo_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, resetn = 0, read = 0, write = 0, run = 0, loop_en = 0, tp = 0, tn = 0, rp = 0, rn = 0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rdv, pen;
  logic waitrequest, tx_line_clock, tx_pos_rail, tx_neg_rail, rx_recovered_clock, rx_line_plus, rx_line_minus;
  logic tx_clock_out, tx_line_pos_out, tx_line_neg_out, rx_clock_out, rx_pos_rail, rx_neg_violation_out, pin_q = 0;
  logic [5:0] half;
  int n_fail = 0, checks = 0, rises = 0, run_len = 0, last_run = 0, sm_rises = 0, r0, n;
  channel_prbs_and_jitter_fifo #(.AW(5)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .tx_line_clock(tx_line_clock), .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail),
    .rx_recovered_clock(rx_recovered_clock), .rx_line_plus(rx_line_plus), .rx_line_minus(rx_line_minus),
    .tx_clock_out(tx_clock_out), .tx_line_pos_out(tx_line_pos_out), .tx_line_neg_out(tx_line_neg_out),
    .rx_clock_out(rx_clock_out), .rx_pos_rail(rx_pos_rail), .rx_neg_violation_out(rx_neg_violation_out));
  framer_model u_far (.run(run), .loop_en(loop_en), .tp(tp), .tn(tn), .rp(rp), .rn(rn),
    .tx_line_pos_out(tx_line_pos_out), .tx_line_neg_out(tx_line_neg_out), .tx_line_clock(tx_line_clock),
    .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail), .rx_recovered_clock(rx_recovered_clock),
    .rx_line_plus(rx_line_plus), .rx_line_minus(rx_line_minus));
  initial forever #5 clk_sys = ~clk_sys;
  // Counts pulses and widths on the violation pin, and smoothed clock edges
  always @(posedge clk_sys) begin
    pin_q <= rx_neg_violation_out;
    if (rx_neg_violation_out === 1'b1 && pin_q !== 1'b1) rises <= rises + 1;
    if (rx_neg_violation_out === 1'b1) run_len <= run_len + 1;
    else begin
      if (run_len != 0) last_run <= run_len;
      run_len <= 0;
    end
  end
  always @(posedge tx_clock_out) sm_rises <= sm_rises + 1;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One Avalon access held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (waitrequest !== 1'b0 && k < 100);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 100) check(32'h0, 32'h1, "bus timeout");
  endtask
  task automatic wait_eq(input logic v, input int lim);
    int k;
    k = 0;
    while (rx_neg_violation_out !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
  endtask
  // Checks the line bits against the recurrence of the polynomial
  task seq_chk(input int a, input int b);
    logic [63:0] h;
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge tx_line_clock);
      h = {h[62:0], tx_line_pos_out};
    end
    for (int k = 0; k < 64 - a; k++) if (h[k] !== (h[k + a] ^ h[k + b])) ok = 1'b0;
    check(32'(ok && h != 64'h0), 32'h1, "sequence recurrence");
  endtask
  task tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    run <= 1'b1;
    bus(1'b0, `OFF_CTRL, 32'h0);
    check(rdv, 32'(`CTRL_RESET), "control reset value");
    bus(1'b0, 4'h8, 32'h0);
    check(rdv, 32'h0, "unmapped read");
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        bus(1'b1, `OFF_CTRL, 32'(c * 2 + p));
        bus(1'b0, `OFF_CTRL, 32'h0);
        check(rdv, 32'(c * 2 + p), "control readback");
        bus(1'b0, `OFF_STATUS, 32'h0);
        check(32'(rdv[`ST_LIMIT]), 32'h0, "limit at centre");
        half = (c == 2) ? 6'h10 : 6'h08;
        if (c == 1 || c == 2) check(32'(rdv[13:8] + 6'h01 - half <= 6'h02), 32'h1, "fill at centre");
      end
    end
    // Short depth in the transmit path, then starve its write clock
    bus(1'b1, `OFF_CTRL, 32'h03);
    run <= 1'b0;
    r0 = sm_rises;
    n = 0;
    while (sm_rises - r0 < 10 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    bus(1'b0, `OFF_STATUS, 32'h0);
    check(32'(rdv[`ST_LIMIT]), 32'h1, "limit near empty");
    bus(1'b0, `OFF_STATUS, 32'h0);
    check(32'(rdv[`ST_LIMIT]), 32'h0, "limit cleared by read");
    check(32'(rdv[13:8] + 6'h01 - 6'h08 <= 6'h02), 32'h1, "buffer recentred");
    run <= 1'b1;
    // Digital and remote loops with opposite levels on the two sides
    for (int v = 0; v < 2; v++) begin
      bus(1'b1, `OFF_CTRL, 32'h40);
      tp <= v[0];
      tn <= ~v[0];
      rp <= ~v[0];
      repeat (8) @(posedge tx_line_clock);
      check(32'({rx_pos_rail, rx_neg_violation_out}), 32'({v[0], ~v[0]}), "digital loop");
      @(negedge tx_line_clock);
      check(32'(rx_clock_out), 32'h1, "digital loop clock");
      bus(1'b1, `OFF_CTRL, 32'h20);
      repeat (8) @(posedge tx_line_clock);
      check(32'({tx_line_pos_out, rx_pos_rail}), 32'({~v[0], ~v[0]}), "remote loop");
      @(negedge tx_line_clock);
      check(32'({tx_clock_out, rx_clock_out}), 32'h3, "remote loop clocks");
    end
    // Pattern mode over an external line loop, both rates
    loop_en <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      pen = 32'h08 | 32'(e << 7);
      bus(1'b1, `OFF_CTRL, pen);
      bus(1'b0, `OFF_STATUS, 32'h0);
      check(32'(rdv[`ST_LOSS]), 32'h1, "loss before lock");
      check(32'(rx_neg_violation_out), 32'h1, "pin high before lock");
      wait_eq(1'b0, 4000);
      check(32'(rx_neg_violation_out), 32'h0, "pin low on lock");
      bus(1'b0, `OFF_STATUS, 32'h0);
      check(32'(rdv[`ST_LOSS]), 32'h0, "loss after lock");
      if (e == 1) seq_chk(23, 18);
      else seq_chk(15, 14);
      r0 = rises;
      bus(1'b1, `OFF_CTRL, pen | 32'h10);
      repeat (64) @(posedge tx_line_clock);
      bus(1'b1, `OFF_CTRL, pen | 32'h10);
      repeat (64) @(posedge tx_line_clock);
      check(32'(rises - r0), 32'h1, "one error per insert");
      check(32'(last_run >= 11 && last_run <= 14), 32'h1, "error pulse width");
      bus(1'b1, `OFF_CTRL, pen);
      bus(1'b1, `OFF_CTRL, pen | 32'h10);
      repeat (64) @(posedge tx_line_clock);
      check(32'(rises - r0), 32'h2, "second insert");
      bus(1'b1, `OFF_CTRL, 32'h0);
    end
    // Analog loop closes the pattern inside the block
    loop_en <= 1'b0;
    bus(1'b1, `OFF_CTRL, 32'h68);
    wait_eq(1'b0, 4000);
    check(32'(rx_neg_violation_out), 32'h0, "analog loop lock");
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
